/* File: verilog/scd_top.sv */
// Purpose: Main/peripheral/CPU clock selection, CPU divider and oscillator stop control.
// Assumes: Clocks are represented as one-cycle tick pulses in the clk domain.
// Notes:   The crystal pin is sampled through three flip-flops before use.
//
// How it works
// - With both source select bits at 1 the crystal clock drives main and peripheral ticks.
// - While the crystal clock is main, the peripheral tick can only come from it.
// - With the CPU source select bit at 0 the CPU tick is the divided main tick.
// - Divider codes 0 to 4 give divide by 1, 2, 4, 8, 16, reset is divide by 2, others ignored.
// - The crystal clock stops on the stop instruction or on a 1 in the main stop bit.
// - The stop instruction enters stop mode, halts oscillation and ignores the clock pin.
// - Bit 0 of the internal oscillator register stops the internal oscillator.
// - Bit 7 of the internal oscillator register reports internal oscillator stability.
// - The stability bit goes to 1 once the internal oscillator has settled.
//
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none

module scd_top #(
  parameter int STAB_BASE = scd_pkg::STAB_BASE_CYC
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Crystal side.
  input  wire logic        crystal_input,
  output logic             xtal_osc_enable,
  // CPU side.
  input  wire logic        stop_insn,
  input  wire logic        wake_req,
  // Clock tick outputs.
  output logic             main_tick,
  output logic             peri_tick,
  output logic             cpu_tick,
  output logic             stop_mode
);

  // ****************************************
  // Registers
  // ****************************************
  logic        main_clock_select_q, main_clock_select_d;
  logic        high_speed_source_select_q, high_speed_source_select_d;
  logic        main_osc_stop_q, main_osc_stop_d;
  logic [2:0]  cpu_div_q, cpu_div_d;
  logic        cpu_clock_source_select_q, cpu_clock_source_select_d;
  logic        internal_osc_stop_q, internal_osc_stop_d;
  logic [2:0]  osc_stabilize_wait_select_q, osc_stabilize_wait_select_d;
  logic        wr_pend_q, wr_pend_d;
  logic [7:0]  wr_addr_q, wr_addr_d;
  logic [31:0] hrdata_q, hrdata_d;

  // ****************************************
  // Clock logic state
  // ****************************************
  logic        x_s1_q, x_s2_q, x_s3_q;
  logic [$clog2(scd_pkg::INT_OSC_DIV_CYC)-1:0] osc_div_q, osc_div_d;
  logic [$clog2(scd_pkg::INT_OSC_SETTLE_CYC+1)-1:0] settle_q, settle_d;
  logic        internal_osc_stable_q, internal_osc_stable_d;
  logic        src_hs_q, src_hs_d;
  logic [3:0]  div_cnt_q, div_cnt_d;
  logic [2:0]  div_act_q, div_act_d;
  logic [19:0] wait_q, wait_d;
  scd_pkg::scd_state_t state_q, state_d;
  logic        cpu_tick_q, cpu_tick_d;
  logic        sw_gap_q, sw_gap_d;

  logic        addr_ok;
  logic        hs_run;
  logic        xtal_edge;
  logic        int_tick;
  logic        want_hs;
  logic        main_raw;
  logic [3:0]  div_top;

  // The bus always answers at once with OKAY.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  assign addr_ok   = hsel & hready & htrans[1];

  // ****************************************
  // Register file
  // ****************************************

  // Writes land in the data phase; reads sample next-state values so a read
  // straight after a write to the same register sees the new data.
  always_comb begin
    main_clock_select_d         = main_clock_select_q;
    high_speed_source_select_d  = high_speed_source_select_q;
    main_osc_stop_d             = main_osc_stop_q;
    cpu_div_d                   = cpu_div_q;
    cpu_clock_source_select_d   = cpu_clock_source_select_q;
    internal_osc_stop_d         = internal_osc_stop_q;
    osc_stabilize_wait_select_d = osc_stabilize_wait_select_q;
    wr_pend_d                   = addr_ok & hwrite;
    wr_addr_d                   = haddr;
    hrdata_d                    = hrdata_q;
    if (wr_pend_q) begin
      if (wr_addr_q == scd_pkg::MAIN_CLOCK_MODE_OFS) begin
        main_clock_select_d        = hwdata[scd_pkg::MODE_MAIN_SEL_BIT];
        high_speed_source_select_d = hwdata[scd_pkg::MODE_HS_SEL_BIT];
        main_osc_stop_d            = hwdata[scd_pkg::MODE_OSC_STOP_BIT];
      end else if (wr_addr_q == scd_pkg::CPU_CLOCK_CONTROL_OFS) begin
        cpu_clock_source_select_d = hwdata[scd_pkg::CPU_SRC_BIT];
        // Prohibited codes are dropped so the divider never sees them.
        if (hwdata[scd_pkg::CPU_DIV_LSB +: 3] <= scd_pkg::CPU_DIV_MAX) begin
          cpu_div_d = hwdata[scd_pkg::CPU_DIV_LSB +: 3];
        end
      end else if (wr_addr_q == scd_pkg::INTERNAL_OSC_MODE_OFS) begin
        internal_osc_stop_d = hwdata[scd_pkg::INT_OSC_STOP_BIT];
      end else if (wr_addr_q == scd_pkg::OSC_WAIT_SELECT_OFS) begin
        osc_stabilize_wait_select_d = hwdata[scd_pkg::WAIT_SEL_LSB +: 3];
      end
    end
    if (addr_ok & ~hwrite) begin
      hrdata_d = 32'h0000_0000;
      if (haddr == scd_pkg::MAIN_CLOCK_MODE_OFS) begin
        hrdata_d[scd_pkg::MODE_MAIN_SEL_BIT]  = main_clock_select_d;
        hrdata_d[scd_pkg::MODE_HS_SEL_BIT]    = high_speed_source_select_d;
        hrdata_d[scd_pkg::MODE_OSC_STOP_BIT]  = main_osc_stop_d;
        hrdata_d[scd_pkg::MODE_HS_ACTIVE_BIT] = src_hs_q;
        hrdata_d[scd_pkg::MODE_STOP_BIT]      = stop_mode;
      end else if (haddr == scd_pkg::CPU_CLOCK_CONTROL_OFS) begin
        hrdata_d[scd_pkg::CPU_DIV_LSB +: 3] = cpu_div_d;
        hrdata_d[scd_pkg::CPU_SRC_BIT]      = cpu_clock_source_select_d;
      end else if (haddr == scd_pkg::INTERNAL_OSC_MODE_OFS) begin
        hrdata_d[scd_pkg::INT_OSC_STOP_BIT]   = internal_osc_stop_d;
        hrdata_d[scd_pkg::INT_OSC_STABLE_BIT] = internal_osc_stable_q;
      end else if (haddr == scd_pkg::OSC_WAIT_SELECT_OFS) begin
        hrdata_d[scd_pkg::WAIT_SEL_LSB +: 3] = osc_stabilize_wait_select_d;
      end
    end
  end

  // Register state.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      main_clock_select_q         <= 1'b0;
      high_speed_source_select_q  <= 1'b0;
      main_osc_stop_q             <= 1'b0;
      cpu_div_q                   <= scd_pkg::CPU_DIV_RESET;
      cpu_clock_source_select_q   <= 1'b0;
      internal_osc_stop_q         <= 1'b0;
      osc_stabilize_wait_select_q <= scd_pkg::WAIT_SEL_RESET;
      wr_pend_q                   <= 1'b0;
      wr_addr_q                   <= 8'h00;
      hrdata_q                    <= 32'h0000_0000;
    end else begin
      main_clock_select_q         <= main_clock_select_d;
      high_speed_source_select_q  <= high_speed_source_select_d;
      main_osc_stop_q             <= main_osc_stop_d;
      cpu_div_q                   <= cpu_div_d;
      cpu_clock_source_select_q   <= cpu_clock_source_select_d;
      internal_osc_stop_q         <= internal_osc_stop_d;
      osc_stabilize_wait_select_q <= osc_stabilize_wait_select_d;
      wr_pend_q                   <= wr_pend_d;
      wr_addr_q                   <= wr_addr_d;
      hrdata_q                    <= hrdata_d;
    end
  end

  // ****************************************
  // Sources
  // ****************************************

  // The crystal runs only outside stop mode and while not stopped by software.
  assign hs_run          = (state_q == scd_pkg::SCD_RUN) & ~main_osc_stop_q;
  assign xtal_osc_enable = hs_run;
  // Edges are taken from the second and third stages only.
  assign xtal_edge       = x_s2_q & ~x_s3_q & hs_run;
  assign int_tick        = (osc_div_q == '0) & ~internal_osc_stop_q;
  assign want_hs         = high_speed_source_select_q & main_clock_select_q;
  // Main and peripheral ticks share one source, so the peripheral tick
  // cannot come from elsewhere while the crystal is main.
  // The cycle after a switch stays quiet, so an old and a new tick never abut.
  assign main_raw        = ~sw_gap_q & (src_hs_q ? xtal_edge : int_tick);
  assign main_tick       = main_raw;
  assign peri_tick       = main_raw;
  assign cpu_tick        = cpu_tick_q;
  assign stop_mode       = (state_q != scd_pkg::SCD_RUN);
  assign div_top         = 4'((1 << div_act_q) - 1);

  // Source switch, internal oscillator, settling and divider.
  always_comb begin
    osc_div_d             = osc_div_q + 1'b1;
    settle_d              = settle_q;
    internal_osc_stable_d = internal_osc_stable_q;
    src_hs_d              = src_hs_q;
    div_cnt_d             = div_cnt_q;
    div_act_d             = div_act_q;
    cpu_tick_d            = 1'b0;
    sw_gap_d              = 1'b0;
    if (osc_div_q == $bits(osc_div_q)'(scd_pkg::INT_OSC_DIV_CYC - 1)) begin
      osc_div_d = '0;
    end
    // Stability follows a settle count after each restart.
    if (internal_osc_stop_q) begin
      settle_d              = '0;
      internal_osc_stable_d = 1'b0;
    end else if (settle_q == $bits(settle_q)'(scd_pkg::INT_OSC_SETTLE_CYC)) begin
      internal_osc_stable_d = 1'b1;
    end else begin
      settle_d = settle_q + 1'b1;
    end
    // Switch only as the old source ticks, or if it has died, so no runt appears.
    if ((want_hs != src_hs_q) & (main_raw | (src_hs_q ? ~hs_run : internal_osc_stop_q))) begin
      src_hs_d  = want_hs;
      sw_gap_d  = 1'b1;
      div_cnt_d = '0;
    end else if (main_raw) begin
      if (div_cnt_q >= div_top) begin
        div_cnt_d  = '0;
        div_act_d  = cpu_div_q;
        // A held source select bit or a running wake wait keeps the CPU idle.
        cpu_tick_d = ~cpu_clock_source_select_q & (state_q == scd_pkg::SCD_RUN)
                     & (wait_q == '0);
      end else begin
        div_cnt_d = div_cnt_q + 1'b1;
      end
    end
  end

  // Source state.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      x_s1_q                <= 1'b0;
      x_s2_q                <= 1'b0;
      x_s3_q                <= 1'b0;
      osc_div_q             <= '0;
      settle_q              <= '0;
      internal_osc_stable_q <= 1'b0;
      src_hs_q              <= 1'b0;
      div_cnt_q             <= 4'h0;
      div_act_q             <= scd_pkg::CPU_DIV_RESET;
      cpu_tick_q            <= 1'b0;
      sw_gap_q              <= 1'b0;
    end else begin
      x_s1_q                <= crystal_input;
      x_s2_q                <= x_s1_q;
      x_s3_q                <= x_s2_q;
      osc_div_q             <= osc_div_d;
      settle_q              <= settle_d;
      internal_osc_stable_q <= internal_osc_stable_d;
      src_hs_q              <= src_hs_d;
      div_cnt_q             <= div_cnt_d;
      div_act_q             <= div_act_d;
      cpu_tick_q            <= cpu_tick_d;
      sw_gap_q              <= sw_gap_d;
    end
  end

  // ****************************************
  // Stop sequencer
  // ****************************************

  // Peripheral shutdown and the wait setting are software's duty beforehand;
  // the wake wait only applies when the crystal feeds the main clock.
  always_comb begin
    state_d = state_q;
    wait_d  = wait_q;
    case (state_q)
      scd_pkg::SCD_RUN: begin
        if (wait_q != '0) begin
          wait_d = wait_q - 1'b1;
        end
        if (stop_insn) begin
          state_d = scd_pkg::SCD_STOPPED;
        end
      end
      scd_pkg::SCD_STOPPED: begin
        if (wake_req) begin
          state_d = scd_pkg::SCD_WAKE_WAIT;
        end
      end
      default: begin
        state_d = scd_pkg::SCD_RUN;
        if (src_hs_q) begin
          // Wait setting chosen before the stop sets the restart delay.
          wait_d = 20'(STAB_BASE << ((osc_stabilize_wait_select_q > scd_pkg::WAIT_SEL_MAX)
                   ? scd_pkg::WAIT_SEL_MAX : osc_stabilize_wait_select_q));
        end
      end
    endcase
  end

  // Sequencer state.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= scd_pkg::SCD_RUN;
      wait_q  <= 20'h00000;
    end else begin
      state_q <= state_d;
      wait_q  <= wait_d;
    end
  end

endmodule // scd_top

`default_nettype wire

/* File: pkg/scd_pkg.sv */
// Purpose: Shared constants for the system clock select and divider block.
// Assumes: 100 MHz system clock, AHB-Lite register access, word-aligned registers.
// Notes:   Offsets are byte addresses; every register takes one 32-bit word.
package scd_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] MAIN_CLOCK_MODE_OFS   = 8'h00;
  localparam logic [7:0] CPU_CLOCK_CONTROL_OFS = 8'h04;
  localparam logic [7:0] INTERNAL_OSC_MODE_OFS = 8'h08;
  localparam logic [7:0] OSC_WAIT_SELECT_OFS   = 8'h0C;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int MODE_MAIN_SEL_BIT  = 0;
  localparam int MODE_HS_SEL_BIT    = 1;
  localparam int MODE_OSC_STOP_BIT  = 2;
  localparam int MODE_HS_ACTIVE_BIT = 4;
  localparam int MODE_STOP_BIT      = 5;
  localparam int CPU_DIV_LSB        = 0;
  localparam int CPU_SRC_BIT        = 4;
  localparam int INT_OSC_STOP_BIT   = 0;
  localparam int INT_OSC_STABLE_BIT = 7;
  localparam int WAIT_SEL_LSB       = 0;

  // ****************************************
  // Reset values and encodings
  // ****************************************
  localparam logic [2:0] CPU_DIV_RESET  = 3'h1;
  localparam logic [2:0] CPU_DIV_MAX    = 3'h4;
  localparam logic [2:0] WAIT_SEL_RESET = 3'h5;
  localparam logic [2:0] WAIT_SEL_MAX   = 3'h4;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS       = 10;
  localparam int INT_OSC_SETTLE_NS   = 1000;
  localparam int INT_OSC_SETTLE_CYC  = (INT_OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INT_OSC_DIV_CYC     = 2;
  localparam int STAB_BASE_CYC       = 256;

  // Stop-mode sequencer.
  typedef enum logic [1:0] {
    SCD_RUN,
    SCD_STOPPED,
    SCD_WAKE_WAIT
  } scd_state_t;

endpackage

/* File: verif/scd_top_sva.sv */
// Purpose: Port-level assertions for the clock select and divider block.
// Assumes: One clock domain with a synchronous, active-high reset.
// Notes:   Bound into every scd_top instance at the foot of this file.
`timescale 1ns/10ps
`default_nettype none

module scd_top_chk #(
  parameter int STAB_BASE = 4
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Stop control and tick outputs.
  input wire logic stop_insn,
  input wire logic wake_req,
  input wire logic stop_mode,
  input wire logic xtal_osc_enable,
  input wire logic main_tick,
  input wire logic peri_tick,
  input wire logic cpu_tick
);
  // ****************************************
  // Clock tree relations
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // The peripheral clock can never come from anywhere but the main clock.
  peri_follow_a: assert property (peri_tick == main_tick)
    else $error("peripheral tick differs from main tick");
  // A tick longer than one cycle would be a stretched, glitchy clock.
  main_gap_a: assert property (main_tick |=> !main_tick)
    else $error("main tick lasted two cycles");
  cpu_gap_a: assert property (cpu_tick |=> !cpu_tick)
    else $error("cpu tick lasted two cycles");
  // Every CPU tick ends a divide period, so a main tick precedes it.
  cpu_cause_a: assert property (cpu_tick |-> $past(main_tick))
    else $error("cpu tick without a preceding main tick");
  // The stop instruction halts the crystal on the very next cycle.
  stop_entry_a: assert property (stop_insn && !stop_mode |=> stop_mode && !xtal_osc_enable)
    else $error("stop instruction did not enter stop mode");
  stop_osc_a: assert property (stop_mode |-> !xtal_osc_enable)
    else $error("crystal enabled in stop mode");
  // Wake passes through one wait cycle and then leaves stop mode.
  wake_exit_a: assert property (stop_mode && wake_req |=> stop_mode ##1 !stop_mode)
    else $error("stop mode release took the wrong number of cycles");
  stop_hold_a: assert property (stop_mode && !wake_req && !$past(wake_req) |=> stop_mode)
    else $error("stop mode left without a wake request");

  // Main scenarios reached.
  stop_seen_c: cover property ($rose(stop_mode));
  cpu_seen_c: cover property (cpu_tick);
  xtal_seen_c: cover property (main_tick && xtal_osc_enable);
endmodule // scd_top_chk

bind scd_top scd_top_chk #(.STAB_BASE(STAB_BASE)) scd_top_chk_inst (
  .clk(clk), .sys_rst(sys_rst), .stop_insn(stop_insn), .wake_req(wake_req),
  .stop_mode(stop_mode), .xtal_osc_enable(xtal_osc_enable), .main_tick(main_tick),
  .peri_tick(peri_tick), .cpu_tick(cpu_tick));

`default_nettype wire

/* File: verif/scd_xtal_model.sv */
// Purpose: Behavioural crystal on the far side of the clock pin.
// Assumes: The block's enable is high while the crystal may swing.
// Notes:   A halted crystal rests low instead of freezing mid-swing.
`timescale 1ns/10ps
`default_nettype none

module scd_xtal_model #(
  parameter int HALF_NS = 40
) (
  // Oscillator control and pin.
  input  wire logic enable,
  output logic      crystal_input
);
  // The 3 ns offset keeps pin edges away from the system clock edges.
  initial begin
    crystal_input = 1'b0;
    #3;
    forever begin
      #(HALF_NS);
      crystal_input = enable ? !crystal_input : 1'b0;
    end
  end
endmodule // scd_xtal_model

`default_nettype wire

/* File: verif/system_clock_select_divider_test.sv */
// Purpose: Self-checking bench for the clock select and divider block.
// Assumes: No bus wait states; the crystal swings with an 80 ns period.
// Notes:   STAB_BASE is cut to 4 so the wake hold-off stays short.
`timescale 1ns/10ps
`default_nettype none

module system_clock_select_divider_test;
  // Bench signals.
  logic        clk, sys_rst, hsel, hwrite, stop_insn, wake_req;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata, rd, n;
  logic        hreadyout, hresp, crystal_input, xtal_osc_enable;
  logic        main_tick, peri_tick, cpu_tick, stop_mode;
  int          n_fail, num_checks, cyc;

  // Block under test and its crystal.
  scd_top #(.STAB_BASE(4)) scd_top_inst (
    .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .crystal_input(crystal_input), .xtal_osc_enable(xtal_osc_enable),
    .stop_insn(stop_insn), .wake_req(wake_req), .main_tick(main_tick),
    .peri_tick(peri_tick), .cpu_tick(cpu_tick), .stop_mode(stop_mode));
  scd_xtal_model scd_xtal_model_inst (.enable(xtal_osc_enable), .crystal_input(crystal_input));

  // ****************************************
  // Clock, hang guard and helpers
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // The run needs under 1000 cycles, so 6000 means a hang.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // One AHB-Lite single transfer; returns at the edge that ends the data phase.
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d, rd);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0, rd);
    check(rd, exp);
  endtask

  function automatic logic tick(input int sel);
    return (sel == 0) ? main_tick : (sel == 1) ? peri_tick : cpu_tick;
  endfunction

  // Cycles from one tick to the next; a bounded wait so a dead clock shows.
  task automatic measure(input int sel, output logic [31:0] cnt);
    int k;
    k = 0;
    cnt = 32'h0;
    do begin @(posedge clk); k++; end while (tick(sel) !== 1'b1 && k < 400);
    do begin @(posedge clk); cnt++; end while (tick(sel) !== 1'b1 && cnt < 400);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_reset;
    rdchk(8'h08, 32'h0000_0000);
    rdchk(8'h04, 32'h0000_0001);
    rdchk(8'h0C, 32'h0000_0005);
    rdchk(8'h10, 32'h0000_0000);
    // The bus never stalls and never reports an error.
    check({30'h0, hreadyout, hresp}, 32'h2);
    repeat (110) @(posedge clk);
    rdchk(8'h08, 32'h0000_0080);
    $display("reset test done");
  endtask

  // Internal source ticks every 2 cycles, so code c gives 2 << c cycles.
  task automatic test_divider;
    for (int c = 0; c < 5; c++) begin
      wr(8'h04, 32'(c));
      measure(2, n);
      measure(2, n);
      check(n, 32'h2 << c);
    end
    wr(8'h04, 32'h0000_0005);
    rdchk(8'h04, 32'h0000_0004);
    wr(8'h04, 32'h0000_0016);
    rdchk(8'h04, 32'h0000_0014);
    repeat (40) @(posedge clk);
    n = 32'h0;
    repeat (80) begin
      @(posedge clk);
      if (cpu_tick === 1'b1) n++;
    end
    check(n, 32'h0);
    wr(8'h04, 32'h0000_0001);
    $display("divider test done");
  endtask

  task automatic test_crystal;
    wr(8'h00, 32'h0000_0003);
    measure(0, n);
    measure(0, n);
    check(n, 32'h8);
    measure(1, n);
    check(n, 32'h8);
    rdchk(8'h00, 32'h0000_0013);
    measure(2, n);
    measure(2, n);
    check(n, 32'h10);
    wr(8'h08, 32'h0000_0001);
    bus(8'h08, 1'b0, 32'h0, rd);
    check({31'h0, rd[0]}, 32'h1);
    wr(8'h08, 32'h0000_0000);
    $display("crystal test done");
  endtask

  task automatic test_osc_stop;
    wr(8'h00, 32'h0000_0000);
    wr(8'h00, 32'h0000_0004);
    repeat (2) @(posedge clk);
    check({31'h0, xtal_osc_enable}, 32'h0);
    wr(8'h00, 32'h0000_0000);
    repeat (2) @(posedge clk);
    check({31'h0, xtal_osc_enable}, 32'h1);
    repeat (120) @(posedge clk);
    rdchk(8'h08, 32'h0000_0080);
    $display("oscillator stop test done");
  endtask

  // Software side: no peripheral here needs shutting down before a stop.
  task automatic test_stop;
    wr(8'h00, 32'h0000_0003);
    wr(8'h0C, 32'h0000_0000);
    repeat (20) @(posedge clk);
    stop_insn <= 1'b1;
    @(posedge clk);
    stop_insn <= 1'b0;
    @(posedge clk);
    #1;
    check({30'h0, stop_mode, xtal_osc_enable}, 32'h2);
    n = 32'h0;
    repeat (30) begin
      @(posedge clk);
      if (main_tick === 1'b1) n++;
    end
    check(n, 32'h0);
    wake_req <= 1'b1;
    @(posedge clk);
    wake_req <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check({31'h0, stop_mode}, 32'h0);
    measure(2, n);
    measure(2, n);
    check(n, 32'h10);
    $display("stop test done");
  endtask

  // Main sequence.
  initial begin
    {sys_rst, hsel, hwrite, stop_insn, wake_req} = 5'h10;
    haddr = 8'h00;
    htrans = 2'h0;
    hwdata = 32'h0;
    n_fail = 0;
    num_checks = 0;
    cyc = 0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    test_reset();
    test_divider();
    test_crystal();
    test_osc_stop();
    test_stop();
    finish_test();
  end
endmodule // system_clock_select_divider_test

`default_nettype wire
